// *** logic/ufc_pingpong.sv ***
// Transmit double buffer: buffer manager fills one half, DMA drains other
module ufc_pingpong #(
	parameter int HALF = ufc_pkg::HALF_BYTES
) (
	input logic               clk,
	input logic               reset,
	ufc_buf_if.store_side     bus
);
	localparam int HA = $clog2(HALF);

	logic [7:0]    mem [2*HALF];
	logic [HA:0]   fill_count;
	logic [HA:0]   next_fill_count;
	logic [HA:0]   drain_count;
	logic [HA-1:0] drain_ptr;
	logic          swapped;
	logic          swap;
	logic          fill_push;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Swap only with a full fill half and an empty drain half
	// Partial halves never swap: the filler must complete each half
	assign fill_push = bus.fill_valid && bus.fill_ready;
	assign swap = (fill_count == (HA+1)'(HALF)) && (drain_count == '0) && bus.dma_en
		&& (bus.continuous || !swapped);
	assign next_fill_count = swap ? '0 : fill_count + (HA+1)'(fill_push);

	// Both halves live in one array, selected by fill_half
	always_ff @(posedge clk) begin
		if (fill_push)
			mem[{bus.fill_half, fill_count[HA-1:0]}] <= bus.fill_data;
	end
	assign bus.drain_data  = mem[{!bus.fill_half, drain_ptr}];
	assign bus.drain_valid = drain_count != '0;

	// Fill side count and registered ready
	always_ff @(posedge clk) begin
		if (reset) begin
			fill_count     <= '0;
			bus.fill_ready <= 1'b1;
		end else begin
			fill_count     <= next_fill_count;
			bus.fill_ready <= next_fill_count != (HA+1)'(HALF);
		end
	end

	// Drain side and half ownership
	always_ff @(posedge clk) begin
		if (reset) begin
			bus.fill_half <= 1'b0;
			drain_count   <= '0;
			drain_ptr     <= '0;
		end else if (swap) begin
			bus.fill_half <= !bus.fill_half;
			drain_count   <= (HA+1)'(HALF);
			drain_ptr     <= '0;
		end else if (bus.drain_take) begin
			drain_count   <= drain_count - (HA+1)'(1);
			drain_ptr     <= drain_ptr + HA'(1);
		end
	end

	// Without continuous mode only one swap per DMA enable
	always_ff @(posedge clk) begin
		if (reset || !bus.dma_en)
			swapped <= 1'b0;
		else if (swap)
			swapped <= 1'b1;
	end

	AST_SWAP_FULL: assert property ($changed(bus.fill_half) |->
		$past(fill_count) == (HA+1)'(HALF) && $past(drain_count) == '0)
		else $error("half swap without full fill and empty drain");
endmodule : ufc_pingpong

// *** logic/ufc_top.sv ***
// UART channel flow control: xon/xoff, auto RTS/CTS, receive FIFO, registers
//
// Strobed register access and the register offsets were chosen for this implementation.

module ufc_top #(
	parameter int RX_DEPTH = ufc_pkg::RX_DEPTH,
	parameter int HALF     = ufc_pkg::HALF_BYTES
) (
	input  logic       clk,
	input  logic       reset,
	input  logic [3:0] reg_addr,
	input  logic [7:0] reg_wdata,
	input  logic       reg_wr,
	input  logic       reg_rd,
	output logic [7:0] reg_rdata,
	input  logic       rx_valid,
	input  logic [7:0] rx_data,
	input  logic       rx_dma_ready,
	output logic       rx_dma_valid,
	output logic [7:0] rx_dma_data,
	input  logic       bm_valid,
	input  logic [7:0] bm_data,
	output logic       bm_ready,
	input  logic       thr_ready,
	output logic       thr_load,
	output logic [7:0] thr_data,
	input  logic       cts_n,
	output logic       rts,
	input  logic       modem_event,
	input  logic       line_event,
	output logic       irq
);
	localparam int RXA = $clog2(RX_DEPTH);
	localparam int IW  = ufc_pkg::IRQ_W;

	logic [7:0]     xon_char;
	logic [7:0]     xoff_char;
	logic [2:0]     uart_irq_mask;
	logic [2:0]     flow_ctrl_reg;
	logic [7:0]     modem_control_reg;
	logic [1:0]     dma_channel_def_reg;
	logic [IW-1:0]  irq_status;
	logic [IW-1:0]  irq_enable;
	logic [IW-1:0]  irq_set;
	logic [IW-1:0]  irq_clr;
	logic [7:0]     stat_word;
	logic           cts_meta;
	logic           cts_sync;
	logic [7:0]     rx_mem [RX_DEPTH];
	logic [RXA-1:0] rx_wp;
	logic [RXA-1:0] rx_rp;
	logic [RXA:0]   rx_level;
	logic [RXA:0]   next_rx_level;
	logic           rx_push;
	logic           rx_pop;
	logic           rx_halt;
	logic           next_rx_halt;
	logic           sw_fc;
	logic           cts_block;
	logic           tx_paused;
	logic           xon_hit;
	logic           xoff_hit;
	logic           xon_pend;
	logic           xoff_pend;
	logic           tx_free;
	logic           send_xon;
	logic           send_xoff;
	logic           dma_go;
	logic           thr_ready_d;
	ufc_pkg::ufc_tx_t tx_state;

	ufc_buf_if bus ();

	ufc_pingpong #(
		.HALF (HALF)
	) u_buf (
		.clk   (clk),
		.reset (reset),
		.bus   (bus)
	);

	// Buffer manager fill path and DMA controls
	assign bus.fill_valid = bm_valid;
	assign bus.fill_data  = bm_data;
	assign bus.dma_en     = dma_channel_def_reg[ufc_pkg::DMA_EN];
	assign bus.continuous = dma_channel_def_reg[ufc_pkg::DMA_CONT];
	assign bm_ready       = bus.fill_ready;

	// Register writes; unmapped offsets are ignored
	always_ff @(posedge clk) begin
		if (reset) begin
			xon_char            <= ufc_pkg::XON_RST;
			xoff_char           <= ufc_pkg::XOFF_RST;
			uart_irq_mask       <= ufc_pkg::MASK_RST;
			flow_ctrl_reg       <= ufc_pkg::FLOW_RST;
			modem_control_reg   <= ufc_pkg::MODEM_RST;
			dma_channel_def_reg <= ufc_pkg::DMA_RST;
			irq_enable          <= ufc_pkg::IRQ_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				ufc_pkg::OFS_XON:    xon_char            <= reg_wdata;
				ufc_pkg::OFS_XOFF:   xoff_char           <= reg_wdata;
				ufc_pkg::OFS_MASK:   uart_irq_mask       <= reg_wdata[2:0];
				ufc_pkg::OFS_FLOW:   flow_ctrl_reg       <= reg_wdata[2:0];
				ufc_pkg::OFS_MODEM:  modem_control_reg   <= reg_wdata;
				ufc_pkg::OFS_DMA:    dma_channel_def_reg <= reg_wdata[1:0];
				ufc_pkg::OFS_IRQ_EN: irq_enable          <= reg_wdata[IW-1:0];
				default: ;
			endcase
		end
	end

	// Status word seen by software
	always_comb begin
		stat_word = 8'h00;
		stat_word[ufc_pkg::STAT_RTS]    = rts;
		stat_word[ufc_pkg::STAT_PAUSED] = tx_paused;
		stat_word[ufc_pkg::STAT_CTS]    = cts_sync;
		stat_word[ufc_pkg::STAT_HALF]   = bus.fill_half;
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (reset || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				ufc_pkg::OFS_XON:      reg_rdata <= xon_char;
				ufc_pkg::OFS_XOFF:     reg_rdata <= xoff_char;
				ufc_pkg::OFS_MASK:     reg_rdata <= {5'h00, uart_irq_mask};
				ufc_pkg::OFS_FLOW:     reg_rdata <= {5'h00, flow_ctrl_reg};
				ufc_pkg::OFS_MODEM:    reg_rdata <= modem_control_reg;
				ufc_pkg::OFS_DMA:      reg_rdata <= {6'h00, dma_channel_def_reg};
				ufc_pkg::OFS_STAT:     reg_rdata <= stat_word;
				ufc_pkg::OFS_LEVEL:    reg_rdata <= 8'(rx_level);
				ufc_pkg::OFS_IRQ_STAT: reg_rdata <= {3'h0, irq_status};
				ufc_pkg::OFS_IRQ_EN:   reg_rdata <= {3'h0, irq_enable};
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end

	// CTS pin crosses in through two flops
	always_ff @(posedge clk) begin
		if (reset) begin
			cts_meta <= 1'b0;
			cts_sync <= 1'b0;
		end else begin
			cts_meta <= cts_n;
			cts_sync <= cts_meta;
		end
	end

	// Mode decode; both top modem bits must be clear for character flow
	assign sw_fc = flow_ctrl_reg[ufc_pkg::FLOW_SW]
		&& modem_control_reg[ufc_pkg::MODEM_SW_EN]
		&& !modem_control_reg[ufc_pkg::MODEM_OFF_HI]
		&& !modem_control_reg[ufc_pkg::MODEM_OFF_LO];
	assign cts_block = flow_ctrl_reg[ufc_pkg::FLOW_AUTO_CTS] && cts_sync;

	// Receive FIFO; a byte arriving while full is dropped
	assign rx_push = rx_valid && (rx_level != (RXA+1)'(RX_DEPTH));
	assign rx_pop  = (rx_level != '0) && (!rx_dma_valid || rx_dma_ready);
	assign next_rx_level = rx_level + (RXA+1)'(rx_push) - (RXA+1)'(rx_pop);

	always_ff @(posedge clk) begin
		if (rx_push)
			rx_mem[rx_wp] <= rx_data;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_wp    <= '0;
			rx_rp    <= '0;
			rx_level <= '0;
		end else begin
			rx_wp    <= rx_wp + RXA'(rx_push);
			rx_rp    <= rx_rp + RXA'(rx_pop);
			rx_level <= next_rx_level;
		end
	end

	// Output stage toward the DMA, registered so the port is a flop
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_dma_valid <= 1'b0;
			rx_dma_data  <= 8'h00;
		end else if (rx_pop) begin
			rx_dma_valid <= 1'b1;
			rx_dma_data  <= rx_mem[rx_rp];
		end else if (rx_dma_ready) begin
			rx_dma_valid <= 1'b0;
		end
	end

	// Hysteresis between the two marks; next level so RTS is not late
	always_comb begin
		next_rx_halt = rx_halt;
		if (next_rx_level >= (RXA+1)'(ufc_pkg::HIGH_MARK))
			next_rx_halt = 1'b1;
		else if (next_rx_level <= (RXA+1)'(ufc_pkg::LOW_MARK))
			next_rx_halt = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_halt <= 1'b0;
			rts     <= 1'b0;
		end else begin
			rx_halt <= next_rx_halt;
			rts     <= flow_ctrl_reg[ufc_pkg::FLOW_AUTO_RTS] && next_rx_halt;
		end
	end

	// Character compare on every received byte
	assign xon_hit  = rx_valid && (rx_data == xon_char);
	assign xoff_hit = rx_valid && (rx_data == xoff_char);

	// Transmit pause; xoff wins when both characters are equal
	always_ff @(posedge clk) begin
		if (reset || !sw_fc)
			tx_paused <= 1'b0;
		else if (xoff_hit)
			tx_paused <= 1'b1;
		else if (xon_hit)
			tx_paused <= 1'b0;
	end

	// Flow character due flags: one per mark crossing
	always_ff @(posedge clk) begin
		if (reset || !sw_fc) begin
			xoff_pend <= 1'b0;
			xon_pend  <= 1'b0;
		end else if (!rx_halt && next_rx_halt) begin
			xoff_pend <= 1'b1;
			xon_pend  <= 1'b0;
		end else if (rx_halt && !next_rx_halt) begin
			xon_pend  <= 1'b1;
			xoff_pend <= 1'b0;
		end else begin
			if (send_xoff)
				xoff_pend <= 1'b0;
			if (send_xon)
				xon_pend <= 1'b0;
		end
	end

	// Next character choice: flow characters ahead of buffered data
	assign tx_free   = (tx_state == ufc_pkg::tx_idle) && thr_ready;
	assign send_xoff = tx_free && xoff_pend;
	assign send_xon  = tx_free && !xoff_pend && xon_pend;
	assign dma_go    = bus.dma_en && !tx_paused && !cts_block;
	assign bus.drain_take = tx_free && !xoff_pend && !xon_pend && dma_go
		&& bus.drain_valid;

	// Load sequencer; hold state gives the holding register a cycle
	// to drop its ready, so one empty slot is never loaded twice
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_state <= ufc_pkg::tx_idle;
			thr_load <= 1'b0;
			thr_data <= 8'h00;
		end else begin
			thr_load <= 1'b0;
			case (tx_state)
				ufc_pkg::tx_idle: begin
					if (send_xoff || send_xon || bus.drain_take) begin
						tx_state <= ufc_pkg::tx_hold;
						thr_load <= 1'b1;
						if (send_xoff)
							thr_data <= xoff_char;
						else if (send_xon)
							thr_data <= xon_char;
						else
							thr_data <= bus.drain_data;
					end
				end
				ufc_pkg::tx_hold: tx_state <= ufc_pkg::tx_idle;
				default:          tx_state <= ufc_pkg::tx_idle;
			endcase
		end
	end

	// Interrupt sources; mask bits gate the UART sources at the set
	always_comb begin
		irq_set = '0;
		irq_set[ufc_pkg::IRQ_MODEM] = modem_event && uart_irq_mask[ufc_pkg::MASK_MODEM];
		irq_set[ufc_pkg::IRQ_LINE]  = line_event && uart_irq_mask[ufc_pkg::MASK_LINE];
		irq_set[ufc_pkg::IRQ_FIFO]  = uart_irq_mask[ufc_pkg::MASK_FIFO]
			&& ((rx_push && next_rx_level == (RXA+1)'(RX_DEPTH))
			|| (thr_ready && !thr_ready_d));
		irq_set[ufc_pkg::IRQ_XON]   = xon_hit;
		irq_set[ufc_pkg::IRQ_XOFF]  = xoff_hit;
	end
	assign irq_clr = (reg_wr && reg_addr == ufc_pkg::OFS_IRQ_CLR) ? reg_wdata[IW-1:0] : '0;

	// Sticky status: a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_status  <= ufc_pkg::IRQ_RST;
			irq         <= 1'b0;
			thr_ready_d <= 1'b0;
		end else begin
			irq_status  <= (irq_status & ~irq_clr) | irq_set;
			irq         <= |(irq_status & irq_enable);
			thr_ready_d <= thr_ready;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_xoff_due;
		tx_free && xoff_pend;
	endsequence
	sequence s_xoff_out;
		thr_load && thr_data == $past(xoff_char) ##1 !thr_load;
	endsequence

	AST_XOFF_FIRST: assert property (s_xoff_due |=> s_xoff_out)
		else $error("due xoff not loaded first");
	AST_RTS_HIGH: assert property ($past(flow_ctrl_reg[ufc_pkg::FLOW_AUTO_RTS])
		&& rx_level >= (RXA+1)'(ufc_pkg::HIGH_MARK) |-> rts)
		else $error("rts low above high mark");
	AST_RTS_LOW: assert property (rx_level <= (RXA+1)'(ufc_pkg::LOW_MARK) |-> !rts)
		else $error("rts high at low mark");
	AST_XON_IRQ: assert property (xon_hit && irq_enable[ufc_pkg::IRQ_XON]
		&& $stable(irq_enable) |=> ##1 irq)
		else $error("xon match gave no interrupt");
	AST_XOFF_PAUSE: assert property (sw_fc && xoff_hit |=> tx_paused)
		else $error("xoff match did not pause");
	AST_XON_RESUME: assert property (sw_fc && xon_hit && !xoff_hit |=> !tx_paused)
		else $error("xon match did not resume");
	AST_CTS_HOLD: assert property (cts_block |-> !bus.drain_take)
		else $error("data taken while cts suspends");
	AST_MASK_RSV: assert property (reg_rd && reg_addr == ufc_pkg::OFS_MASK
		|=> reg_rdata[7:3] == 5'h00)
		else $error("mask reserved bits not zero");
	AST_MODEM_GATE: assert property (!irq_status[ufc_pkg::IRQ_MODEM]
		&& !uart_irq_mask[ufc_pkg::MASK_MODEM] |=> !irq_status[ufc_pkg::IRQ_MODEM])
		else $error("masked modem event set status");
	AST_LINE_GATE: assert property (!irq_status[ufc_pkg::IRQ_LINE]
		&& !uart_irq_mask[ufc_pkg::MASK_LINE] |=> !irq_status[ufc_pkg::IRQ_LINE])
		else $error("masked line event set status");
endmodule : ufc_top

// *** shared/ufc_buf_if.sv ***
// Link between flow control and the transmit ping-pong buffer
interface ufc_buf_if;
	logic       fill_valid;
	logic       fill_ready;
	logic [7:0] fill_data;
	logic       drain_valid;
	logic       drain_take;
	logic [7:0] drain_data;
	logic       dma_en;
	logic       continuous;
	logic       fill_half;
	modport store_side (
		input  fill_valid, fill_data, drain_take, dma_en, continuous,
		output fill_ready, drain_valid, drain_data, fill_half
	);
	modport ctl_side (
		output fill_valid, fill_data, drain_take, dma_en, continuous,
		input  fill_ready, drain_valid, drain_data, fill_half
	);
endinterface : ufc_buf_if

// *** shared/ufc_pkg.sv ***
// Constants and types of the UART flow-control block
package ufc_pkg;
	// Register offsets
	localparam logic [3:0] OFS_XON      = 4'h0;
	localparam logic [3:0] OFS_XOFF     = 4'h1;
	localparam logic [3:0] OFS_MASK     = 4'h2;
	localparam logic [3:0] OFS_FLOW     = 4'h3;
	localparam logic [3:0] OFS_MODEM    = 4'h4;
	localparam logic [3:0] OFS_DMA      = 4'h5;
	localparam logic [3:0] OFS_STAT     = 4'h6;
	localparam logic [3:0] OFS_LEVEL    = 4'h7;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_CLR  = 4'h9;
	localparam logic [3:0] OFS_IRQ_EN   = 4'hA;
	// Reset values
	localparam logic [7:0] XON_RST   = 8'h00;
	localparam logic [7:0] XOFF_RST  = 8'h00;
	localparam logic [2:0] MASK_RST  = 3'h0;
	localparam logic [2:0] FLOW_RST  = 3'h0;
	localparam logic [7:0] MODEM_RST = 8'h00;
	localparam logic [1:0] DMA_RST   = 2'h0;
	localparam logic [4:0] IRQ_RST   = 5'h00;
	// Field positions
	localparam int MASK_MODEM    = 0;
	localparam int MASK_LINE     = 1;
	localparam int MASK_FIFO     = 2;
	localparam int FLOW_AUTO_CTS = 0;
	localparam int FLOW_AUTO_RTS = 1;
	localparam int FLOW_SW       = 2;
	localparam int MODEM_SW_EN   = 5;
	localparam int MODEM_OFF_LO  = 6;
	localparam int MODEM_OFF_HI  = 7;
	localparam int DMA_EN        = 0;
	localparam int DMA_CONT      = 1;
	localparam int STAT_RTS      = 0;
	localparam int STAT_PAUSED   = 1;
	localparam int STAT_CTS      = 2;
	localparam int STAT_HALF     = 3;
	localparam int IRQ_MODEM     = 0;
	localparam int IRQ_LINE      = 1;
	localparam int IRQ_FIFO      = 2;
	localparam int IRQ_XON       = 3;
	localparam int IRQ_XOFF      = 4;
	localparam int IRQ_W         = 5;
	// Sizes and marks
	localparam int RX_DEPTH   = 32;
	localparam int HIGH_MARK  = 12;
	localparam int LOW_MARK   = 4;
	localparam int HALF_BYTES = 32;
	// Transmit sequencer
	typedef enum logic {
		tx_idle = 1'b0,
		tx_hold = 1'b1
	} ufc_tx_t;
endpackage : ufc_pkg

// *** sim/tb_uart_flow_control_buffering.sv ***
// Self-checking bench of the UART flow-control block
module tb_uart_flow_control_buffering;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic       rx_dma_ready = 1'b0;
	logic       bm_valid = 1'b0;
	logic [7:0] bm_data = 8'h00;
	logic       stop = 1'b0;
	logic       modem_event = 1'b0;
	logic       line_event = 1'b0;
	logic [7:0] reg_rdata, rx_dma_data, thr_data;
	logic       rx_dma_valid, bm_ready, thr_ready, thr_load, cts_n, rts, irq;
	logic [7:0] sq[$], rq[$], bq[$], tq[$];
	logic [7:0] v, xon, xoff;
	logic       hyst = 1'b0;
	int         miscompares = 0;
	int         checked = 0;
	int         cycles = 0;
	int         seed = 81461;
	int         i, n;

	ufc_top i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_dma_ready(rx_dma_ready), .rx_dma_valid(rx_dma_valid),
		.rx_dma_data(rx_dma_data), .bm_valid(bm_valid), .bm_data(bm_data),
		.bm_ready(bm_ready), .thr_ready(thr_ready), .thr_load(thr_load),
		.thr_data(thr_data), .cts_n(cts_n), .rts(rts), .modem_event(modem_event),
		.line_event(line_event), .irq(irq));
	ufc_serial_dev i_dev (.clk(clk), .reset(reset), .thr_load(thr_load),
		.thr_data(thr_data), .stop(stop), .thr_ready(thr_ready), .cts_n(cts_n));

	// Clock at 100 MHz
	always #5 clk = ~clk;

	// Hang guard: far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			print_verdict();
		end
	end

	// Buffer-manager side holds each byte until the fill half takes it
	always @(posedge clk) begin
		if (bm_valid && bm_ready)
			void'(bq.pop_front());
		bm_valid <= (bq.size() > 0);
		bm_data  <= (bq.size() > 0) ? bq[0] : 8'h00;
	end

	// Receive DMA side collects every byte handed over
	always @(posedge clk) begin
		if (rx_dma_valid && rx_dma_ready)
			rq.push_back(rx_dma_data);
	end

	task automatic print_verdict();
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic rx_send(input logic [7:0] d);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data  <= d;
		@(posedge clk);
		rx_valid <= 1'b0;
	endtask : rx_send

	task automatic wait_c(input int k);
		repeat (k) @(posedge clk);
	endtask : wait_c

	// Halt state with hysteresis between the two marks
	function automatic logic mark_state(input logic prev, input logic [7:0] lvl);
		if (lvl >= ufc_pkg::HIGH_MARK)
			return 1'b1;
		return (lvl <= ufc_pkg::LOW_MARK) ? 1'b0 : prev;
	endfunction : mark_state

	task automatic rts_check();
		rd(ufc_pkg::OFS_LEVEL, v);
		hyst = mark_state(hyst, v);
		check("rts", {7'h00, hyst}, {7'h00, rts});
	endtask : rts_check

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// Offsets 0 to 11, unmapped 11 and write-only 9 included, read zero after reset
		for (i = 0; i < 12; i++) begin
			rd(4'(i), v);
			check("reset value", 8'h00, v);
		end
		wr(ufc_pkg::OFS_MASK, 8'hFF);
		rd(ufc_pkg::OFS_MASK, v);
		check("mask", 8'h07, v);
		wr(ufc_pkg::OFS_IRQ_EN, 8'h1F);
		// Each of the four modem/line mask patterns gates the modem and line sources
		for (i = 0; i < 4; i++) begin
			wr(ufc_pkg::OFS_MASK, 8'(i));
			wr(ufc_pkg::OFS_IRQ_CLR, 8'h1F);
			@(posedge clk);
			modem_event <= 1'b1;
			line_event  <= 1'b1;
			@(posedge clk);
			modem_event <= 1'b0;
			line_event  <= 1'b0;
			wait_c(3);
			check("irq", {7'h00, i != 0}, {7'h00, irq});
			rd(ufc_pkg::OFS_IRQ_STAT, v);
			check("irq status", 8'(i), v);
		end
		wr(ufc_pkg::OFS_IRQ_CLR, 8'h1F);
		wait_c(3);
		check("irq cleared", 8'h00, {7'h00, irq});
		// Receive flow: marks drive RTS and flow characters
		xon  = 8'($random(seed)) & 8'h7F;
		xoff = xon ^ 8'h01;
		wr(ufc_pkg::OFS_XON, xon);
		wr(ufc_pkg::OFS_XOFF, xoff);
		rd(ufc_pkg::OFS_XOFF, v);
		check("xoff char", xoff, v);
		wr(ufc_pkg::OFS_MODEM, 8'h20);
		wr(ufc_pkg::OFS_FLOW, 8'h06);
		wr(ufc_pkg::OFS_MASK, 8'h04);
		i_dev.got.delete();
		// Overfill: 32 in the FIFO plus one in the output stage survive
		for (n = 0; n < 40; n++) begin
			v = 8'($random(seed)) | 8'h80;
			if (n < 33)
				sq.push_back(v);
			rx_send(v);
			rts_check();
		end
		rd(ufc_pkg::OFS_LEVEL, v);
		check("full level", 8'h20, v);
		rd(ufc_pkg::OFS_IRQ_STAT, v);
		check("full irq", 8'h04, v & 8'h04);
		check("xoff count", 8'h01, 8'(i_dev.got.size()));
		check("xoff sent", xoff, i_dev.got[0]);
		// Drain one byte at a time, watching RTS fall at the low mark
		for (n = 0; n < 400 && rq.size() < 33; n++) begin
			@(posedge clk);
			rx_dma_ready <= 1'b1;
			@(posedge clk);
			rx_dma_ready <= 1'b0;
			wait_c(3);
			rts_check();
		end
		for (i = 0; i < 33; i++)
			check("rx byte", sq[i], (i < rq.size()) ? rq[i] : 8'hXX);
		check("flow chars", 8'h02, 8'(i_dev.got.size()));
		check("xon sent", xon, i_dev.got[1]);
		// Transmit path through the double buffer with pauses
		i_dev.got.delete();
		@(posedge clk) rx_dma_ready <= 1'b1;
		wr(ufc_pkg::OFS_FLOW, 8'h05);
		wr(ufc_pkg::OFS_MASK, 8'h00);
		wr(ufc_pkg::OFS_IRQ_EN, 8'h10);
		wr(ufc_pkg::OFS_IRQ_CLR, 8'h1F);
		for (n = 0; n < 96; n++) begin
			v = 8'($random(seed));
			tq.push_back(v);
			bq.push_back(v);
		end
		wr(ufc_pkg::OFS_DMA, 8'h03);
		for (n = 0; n < 2000 && i_dev.got.size() < 8; n++)
			@(posedge clk);
		rx_send(xoff);
		wait_c(8);
		n = i_dev.got.size();
		wait_c(60);
		check("paused loads", 8'(n), 8'(i_dev.got.size()));
		check("xoff irq", 8'h01, {7'h00, irq});
		rd(ufc_pkg::OFS_IRQ_STAT, v);
		check("xoff status", 8'h10, v);
		wr(ufc_pkg::OFS_IRQ_CLR, 8'h1F);
		rx_send(xon);
		wait_c(60);
		check("resumed", 8'h01, {7'h00, i_dev.got.size() > n});
		check("xon irq gated", 8'h00, {7'h00, irq});
		rd(ufc_pkg::OFS_IRQ_STAT, v);
		check("xon status", 8'h08, v);
		// Enabled xon match must raise the interrupt line
		wr(ufc_pkg::OFS_IRQ_CLR, 8'h1F);
		wr(ufc_pkg::OFS_IRQ_EN, 8'h18);
		rx_send(xon);
		wait_c(3);
		check("xon irq", 8'h01, {7'h00, irq});
		wr(ufc_pkg::OFS_IRQ_CLR, 8'h1F);
		stop <= 1'b1;
		wait_c(8);
		n = i_dev.got.size();
		wait_c(60);
		check("cts held", 8'(n), 8'(i_dev.got.size()));
		stop <= 1'b0;
		for (n = 0; n < 3000 && i_dev.got.size() < 96; n++)
			@(posedge clk);
		check("tx count", 8'h60, 8'(i_dev.got.size()));
		for (i = 0; i < 96 && i < i_dev.got.size(); i++)
			check("tx byte", tq[i], i_dev.got[i]);
		print_verdict();
	end
endmodule : tb_uart_flow_control_buffering

// *** sim/ufc_serial_dev.sv ***
// Far-end serial device model: takes holding-register loads and drives CTS
module ufc_serial_dev (
	input  logic       clk,
	input  logic       reset,
	input  logic       thr_load,
	input  logic [7:0] thr_data,
	input  logic       stop,
	output logic       thr_ready,
	output logic       cts_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got[$];
	int         busy;
	int         pace;
	// Shift time per byte cycles 0..3, so prompt and slow answers both occur
	always @(posedge clk) begin
		if (reset) begin
			thr_ready <= 1'b0;
			busy      <= 0;
			pace      <= 0;
		end else if (thr_load) begin
			got.push_back(thr_data);
			thr_ready <= 1'b0;
			busy      <= pace;
			pace      <= (pace + 1) % 4;
		end else if (busy > 0) begin
			busy <= busy - 1;
		end else begin
			thr_ready <= 1'b1;
		end
	end
	// Stop request raises CTS, unrelated to character timing
	always @(posedge clk) begin
		cts_n <= reset ? 1'b0 : stop;
	end
endmodule : ufc_serial_dev
